// File: hdl/bmf_pkg.sv
// Purpose: shared constants for the third buck mode and fault control
// Assumes: core clock of 25 MHz
// Notes: register offsets are byte addresses on the plain register port
package bmf_pkg;
  // ==========================================================
  // timing
  localparam int BMF_CLK_HZ = 25000000; // core clock rate
  localparam int BMF_DEBOUNCE_US = 8000; // 8.0 ms debounce interval
  localparam int BMF_DEBOUNCE_CYC = BMF_DEBOUNCE_US * (BMF_CLK_HZ / 1000000); // cycles in debounce
  // ==========================================================
  // register map
  localparam logic [7:0] BMF_OFS_CTRL = 8'h00; // control bits
  localparam logic [7:0] BMF_OFS_SETPT = 8'h04; // three set-point fields, read only
  localparam logic [7:0] BMF_OFS_STAT = 8'h08; // mode, sense and state readback
  localparam logic [7:0] BMF_OFS_IRQ = 8'h0c; // sticky fault status, write one to clear
  localparam logic [7:0] BMF_OFS_MASK = 8'h10; // interrupt mask
  // ==========================================================
  // control field positions
  localparam int BMF_CTL_EN = 0; // buck_enable_bit
  localparam int BMF_CTL_STBY = 1; // buck_standby_enable
  localparam int BMF_CTL_SLP = 2; // buck_sleep_enable
  localparam int BMF_CTL_LPWR = 3; // buck_low_bias_select
  localparam int BMF_CTL_FPWM = 4; // buck_forced_pwm_select
  localparam logic [4:0] BMF_CTL_RST = 5'h00; // control reset value
  // ==========================================================
  // set-point fields and code mapping
  localparam int BMF_SP_W = 6; // stored field width
  localparam int BMF_CODE_W = 4; // meaningful code width
  localparam int BMF_MV_BASE = 1800; // code 0000 output in mV
  localparam int BMF_MV_STEP = 100; // mV per code step
  localparam logic [5:0] BMF_SP_RST = 6'h00; // set-point reset value
  // ==========================================================
  // fault bits: 0 high side, 1 low side
  localparam int BMF_NFLT = 2; // number of current-limit sources
  localparam logic [1:0] BMF_FLT_RST = 2'h0; // status and mask reset value
  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {BMF_PS_RUN, BMF_PS_STBY, BMF_PS_SLP, BMF_PS_OFF} bmf_pstate_t; // power state
  typedef enum logic [1:0] {BMF_M_OFF, BMF_M_ADAPT, BMF_M_FPWM, BMF_M_LPWR} bmf_mode_t; // switching mode
endpackage : bmf_pkg

// File: hdl/bmf_debounce.sv
// Purpose: one current-limit debounce channel
// Assumes: raw input already synchronised to core_clk
// Notes: fires one pulse once the level has held past the interval
`timescale 1ns/1ps
module bmf_debounce
  import bmf_pkg::*;
#(
  parameter int HOLD_CYC = BMF_DEBOUNCE_CYC
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic level_in,
  output logic persist_pulse
);
  // ==========================================================
  // persistence counter
  logic [23:0] cnt_r; // cycles the level has held
  logic fired_r; // pulse already given for this episode
  wire logic over_w = (cnt_r >= 24'(HOLD_CYC)); // held longer than interval

  // count while the level stays, restart on any drop
  always_ff @(posedge core_clk)
  begin
    if (srst || !level_in)
    begin
      cnt_r <= 24'h000000;
      fired_r <= 1'b0;
    end
    else
    begin
      if (!over_w)
        cnt_r <= cnt_r + 24'h000001;
      if (over_w)
        fired_r <= 1'b1;
    end
  end

  // single pulse per episode
  assign persist_pulse = level_in && over_w && !fired_r;

  // pulse only on the cycle the count first reaches the interval
  AST_NO_EARLY: assert property (@(posedge core_clk) disable iff (srst)
    persist_pulse |-> $past(level_in) && $past(cnt_r) == 24'(HOLD_CYC - 1))
    else $error("persist pulse before the interval ran out");
endmodule : bmf_debounce

// File: hdl/bmf_ctrl.sv
// Purpose: third buck mode select, set-point load and current-limit faults
// Assumes: power state and limit comparator inputs are asynchronous pins
// Notes: registers reached over a plain strobe port, read data one cycle later
`timescale 1ns/1ps
// Contract
// - code 0000 is 1.80 V, 100 mV steps
// - no dynamic ramping between set-points
// - DCM/CCM automatic, forced by bits or states
// - off and discharged per enable bits
// - adaptive mode is the default
// - forced PWM whenever enabled and bit set
// - run ignores low-power bit
// - standby/sleep low-power bit picks low bias
// - limits cut the switch cycle by cycle
// - limit hit sets sense bit at once
// - status set after 8.0 ms persistence
// - startup copies programmed code into fields
// - set-point fields read only
module bmf_ctrl
  import bmf_pkg::*;
#(
  parameter int HOLD_CYC = BMF_DEBOUNCE_CYC
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] power_state,
  input wire logic [5:0] programmed_setpoint_code,
  input wire logic hs_limit_in,
  input wire logic ls_limit_in,
  input wire logic load_light,
  output logic hs_gate_off,
  output logic ls_gate_off,
  output logic [1:0] buck_mode,
  output logic discharge_on,
  output logic [5:0] active_setpoint,
  output logic [11:0] target_mv,
  output logic irq
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] ps_s1_r; // power state first stage
  logic [1:0] ps_s2_r; // power state usable
  logic [1:0] lim_s1_r; // limit first stage
  logic [1:0] lim_s2_r; // limit usable
  logic light_s1_r; // light-load first stage
  logic light_s2_r; // light-load usable

  // two flops on the power state, limit and light-load inputs
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ps_s1_r <= 2'(BMF_PS_OFF);
      ps_s2_r <= 2'(BMF_PS_OFF);
      lim_s1_r <= 2'h0;
      lim_s2_r <= 2'h0;
      light_s1_r <= 1'b0;
      light_s2_r <= 1'b0;
    end
    else
    begin
      ps_s1_r <= power_state;
      ps_s2_r <= ps_s1_r;
      lim_s1_r <= {ls_limit_in, hs_limit_in};
      lim_s2_r <= lim_s1_r;
      light_s1_r <= load_light;
      light_s2_r <= light_s1_r;
    end
  end

  // ==========================================================
  // register bus decode
  logic [4:0] ctl_r; // control bits
  logic [5:0] sp_run_r; // run_setpoint_field
  logic [5:0] sp_stby_r; // standby_setpoint_field
  logic [5:0] sp_slp_r; // sleep_setpoint_field
  logic [1:0] flt_stat_r; // sticky fault status
  logic [1:0] flt_mask_r; // fault mask
  logic [1:0] ps_prev_r; // power state last cycle
  wire logic wr_ctl = reg_wr && (reg_addr == BMF_OFS_CTRL); // control write
  wire logic wr_irq = reg_wr && (reg_addr == BMF_OFS_IRQ); // status clear write
  wire logic wr_mask = reg_wr && (reg_addr == BMF_OFS_MASK); // mask write
  bmf_pstate_t ps_w; // current power state
  assign ps_w = bmf_pstate_t'(ps_s2_r);

  // control and mask registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctl_r <= BMF_CTL_RST;
      flt_mask_r <= BMF_FLT_RST;
    end
    else
    begin
      if (wr_ctl)
        ctl_r <= reg_wdata[4:0];
      if (wr_mask)
        flt_mask_r <= reg_wdata[1:0];
    end
  end

  // ==========================================================
  // set-point load at start-up; no bus path writes these
  wire logic startup_w = (ps_prev_r == 2'(BMF_PS_OFF)) && (ps_w == BMF_PS_RUN);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sp_run_r <= BMF_SP_RST;
      sp_stby_r <= BMF_SP_RST;
      sp_slp_r <= BMF_SP_RST;
      ps_prev_r <= 2'(BMF_PS_OFF);
    end
    else
    begin
      ps_prev_r <= ps_s2_r;
      // copy the programmed code only on off-to-run; static after
      if (startup_w)
      begin
        sp_run_r <= programmed_setpoint_code;
        sp_stby_r <= programmed_setpoint_code;
        sp_slp_r <= programmed_setpoint_code;
      end
    end
  end

  // ==========================================================
  // mode decode, purely combinational so any change applies at once
  function automatic bmf_mode_t mode_of(input bmf_pstate_t ps, input logic [4:0] c);
    bmf_mode_t m;
    m = BMF_M_ADAPT;
    if (ps == BMF_PS_OFF || !c[BMF_CTL_EN])
      m = BMF_M_OFF;
    else if (ps == BMF_PS_STBY && !c[BMF_CTL_STBY])
      m = BMF_M_OFF;
    else if (ps == BMF_PS_SLP && !c[BMF_CTL_SLP])
      m = BMF_M_OFF;
    else if (c[BMF_CTL_FPWM])
      m = BMF_M_FPWM;
    else if (ps != BMF_PS_RUN && c[BMF_CTL_LPWR])
      m = BMF_M_LPWR;
    else
      m = BMF_M_ADAPT;
    return m;
  endfunction : mode_of

  bmf_mode_t mode_w; // selected mode
  assign mode_w = mode_of(ps_w, ctl_r);
  assign buck_mode = mode_w;
  assign discharge_on = (mode_w == BMF_M_OFF);

  // active set-point by state
  logic [5:0] sp_sel_w; // field of the current state
  assign sp_sel_w = (ps_w == BMF_PS_STBY) ? sp_stby_r : (ps_w == BMF_PS_SLP) ? sp_slp_r : sp_run_r;
  assign active_setpoint = sp_sel_w;
  // linear code to millivolts
  wire logic [11:0] mv_w = 12'(BMF_MV_BASE) + 12'(BMF_MV_STEP) * 12'(sp_sel_w[BMF_CODE_W-1:0]);
  assign target_mv = mv_w;

  // ==========================================================
  // current limits: gate cut from the synchronised comparator
  assign hs_gate_off = lim_s2_r[0];
  assign ls_gate_off = lim_s2_r[1];

  // debounce channels
  logic [1:0] persist_w; // per-source persistence pulses
  genvar gi;
  generate
    for (gi = 0; gi < BMF_NFLT; gi++)
    begin : g_deb
      bmf_debounce #(.HOLD_CYC(HOLD_CYC)) u_deb (
        .core_clk(core_clk),
        .srst(srst),
        .level_in(lim_s2_r[gi]),
        .persist_pulse(persist_w[gi])
      );
    end
  endgenerate

  // sticky status, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flt_stat_r <= BMF_FLT_RST;
    else
      flt_stat_r <= (flt_stat_r & ~(wr_irq ? reg_wdata[1:0] : 2'h0)) | persist_w;
  end

  assign irq = |(flt_stat_r & flt_mask_r);

  // ==========================================================
  // read data, one cycle after the strobe
  logic [31:0] rd_mux_w; // selected read word
  always_comb
  begin
    rd_mux_w = 32'h00000000;
    unique case (reg_addr)
      BMF_OFS_CTRL: rd_mux_w = {27'h0, ctl_r};
      BMF_OFS_SETPT: rd_mux_w = {14'h0, sp_slp_r, sp_stby_r, sp_run_r};
      BMF_OFS_STAT: rd_mux_w = {24'h0, light_s2_r, ps_s2_r, mode_w, 1'b0, lim_s2_r};
      BMF_OFS_IRQ: rd_mux_w = {30'h0, flt_stat_r};
      BMF_OFS_MASK: rd_mux_w = {30'h0, flt_mask_r};
      default: rd_mux_w = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_rd ? rd_mux_w : 32'h00000000;
  end

  // ==========================================================
  // checks
  // limit pin seen two edges back, the depth of the synchroniser
  sequence s_hs_hit;
    hs_limit_in ##2 1'b1;
  endsequence : s_hs_hit

  sequence s_ls_hit;
    ls_limit_in ##2 1'b1;
  endsequence : s_ls_hit

  // high-side status clear and no persistence pulse pending
  sequence s_hs_quiet;
    !flt_stat_r[0] && !persist_w[0];
  endsequence : s_hs_quiet

  // clear write to the high-side bit with no new episode setting it
  sequence s_hs_clear;
    wr_irq && reg_wdata[0] && !persist_w[0];
  endsequence : s_hs_clear

  // off cases: enable bit, standby enable, sleep enable
  AST_OFF_EN: assert property (@(posedge core_clk) disable iff (srst)
    !ctl_r[BMF_CTL_EN] |-> buck_mode == BMF_M_OFF && discharge_on)
    else $error("buck not off with enable clear");
  AST_STBY_OFF: assert property (@(posedge core_clk) disable iff (srst)
    (ps_w == BMF_PS_STBY && !ctl_r[BMF_CTL_STBY]) |-> discharge_on)
    else $error("buck not off in standby with standby enable clear");
  AST_SLP_OFF: assert property (@(posedge core_clk) disable iff (srst)
    (ps_w == BMF_PS_SLP && !ctl_r[BMF_CTL_SLP]) |-> discharge_on)
    else $error("buck not off in sleep with sleep enable clear");

  // mode choice among the enabled cases
  AST_FPWM: assert property (@(posedge core_clk) disable iff (srst)
    (ctl_r[BMF_CTL_FPWM] && mode_w != BMF_M_OFF) |-> mode_w == BMF_M_FPWM)
    else $error("forced pwm not applied");
  AST_RUN_NO_LP: assert property (@(posedge core_clk) disable iff (srst)
    ps_w == BMF_PS_RUN |-> mode_w != BMF_M_LPWR)
    else $error("low power in run");
  AST_STBY_LP: assert property (@(posedge core_clk) disable iff (srst)
    (ps_w == BMF_PS_STBY && ctl_r == 5'h0b) |-> mode_w == BMF_M_LPWR)
    else $error("standby low power missing");
  AST_SLP_ADAPT: assert property (@(posedge core_clk) disable iff (srst)
    (ps_w == BMF_PS_SLP && ctl_r == 5'h05) |-> mode_w == BMF_M_ADAPT)
    else $error("sleep without low bias not adaptive");
  AST_DEFAULT: assert property (@(posedge core_clk) disable iff (srst)
    (ps_w == BMF_PS_RUN && ctl_r == 5'h01) |-> mode_w == BMF_M_ADAPT)
    else $error("adaptive default missing");

  // code to millivolts at both ends of the range
  AST_MV: assert property (@(posedge core_clk) disable iff (srst)
    sp_sel_w[3:0] == 4'hf |-> target_mv == 12'hce4)
    else $error("code 1111 not 3.30 V");
  AST_MV_BASE: assert property (@(posedge core_clk) disable iff (srst)
    sp_sel_w[3:0] == 4'h0 |-> target_mv == 12'h708)
    else $error("code 0000 not 1.80 V");

  // set-point fields: loaded at start-up only
  AST_SP_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !startup_w |=> $stable(sp_run_r) && $stable(sp_stby_r) && $stable(sp_slp_r))
    else $error("set-point changed outside start-up");
  AST_LOAD: assert property (@(posedge core_clk) disable iff (srst)
    startup_w |=> sp_stby_r == $past(programmed_setpoint_code))
    else $error("start-up load missed");

  // sense bits and read port
  AST_SENSE: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == BMF_OFS_STAT |=> reg_rdata[1:0] == $past(lim_s2_r))
    else $error("sense bits wrong");
  AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside the read cycle");

  // switch cut follows the comparator through the synchroniser
  AST_HS_CUT: assert property (@(posedge core_clk) disable iff (srst)
    s_hs_hit |-> hs_gate_off)
    else $error("high side not cut");
  AST_LS_CUT: assert property (@(posedge core_clk) disable iff (srst)
    s_ls_hit |-> ls_gate_off)
    else $error("low side not cut");

  // sticky status: set by persistence only, cleared by a one
  AST_STICKY: assert property (@(posedge core_clk) disable iff (srst)
    persist_w[0] |=> flt_stat_r[0])
    else $error("status not set");
  AST_STICKY_LS: assert property (@(posedge core_clk) disable iff (srst)
    persist_w[1] |=> flt_stat_r[1])
    else $error("low side status not set");
  AST_NO_SET: assert property (@(posedge core_clk) disable iff (srst)
    s_hs_quiet |=> !flt_stat_r[0])
    else $error("status set without persistence");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    s_hs_clear |=> !flt_stat_r[0])
    else $error("status not cleared by write one");
endmodule : bmf_ctrl

// File: test/bmf_host.sv
// Purpose: host model on the plain register port
// Assumes: strobes one cycle long, read data in the cycle after
// Notes: write data is scrambled once the write is over
`timescale 1ns/1ps
module bmf_host
  import bmf_pkg::*;
(
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // ==========================================
  // bus cycles
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write cycle, set-point writes only when a test asks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one read cycle, data taken at the edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : bmf_host

// File: test/tb_top.sv
// Purpose: self-checking bench for the buck mode and fault block
// Assumes: debounce shortened to HOLD cycles
// Notes: all pins driven by non-blocking assignment, at rising edges except power_state at the start of t_fault, driven after a falling edge
`timescale 1ns/1ps
module tb_top
  import bmf_pkg::*;
;
  localparam int HOLD = 20; // short debounce
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] power_state = 2'h3;
  logic [5:0] programmed_setpoint_code = 6'h00;
  logic hs_limit_in = 1'b0;
  logic ls_limit_in = 1'b0;
  logic load_light = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, hs_gate_off, ls_gate_off, discharge_on, irq;
  logic [1:0] buck_mode;
  logic [5:0] active_setpoint;
  logic [11:0] target_mv;
  int failures = 0;
  int checks = 0;
  // ==========================================
  // clock and instances
  always #20 core_clk = ~core_clk;
  bmf_host i_bmf_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bmf_ctrl #(.HOLD_CYC(HOLD)) i_bmf_ctrl (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_state(power_state), .programmed_setpoint_code(programmed_setpoint_code),
    .hs_limit_in(hs_limit_in), .ls_limit_in(ls_limit_in), .load_light(load_light),
    .hs_gate_off(hs_gate_off), .ls_gate_off(ls_gate_off), .buck_mode(buck_mode),
    .discharge_on(discharge_on), .active_setpoint(active_setpoint), .target_mv(target_mv), .irq(irq));
  // ==========================================
  // helpers
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_w
  // expected mode from state and control bits
  function automatic bmf_mode_t exp_mode(input logic [1:0] ps, input logic [4:0] c);
    if (!c[0] || ps == 2'h3 || (ps == 2'h1 && !c[1]) || (ps == 2'h2 && !c[2]))
      return BMF_M_OFF;
    if (c[4])
      return BMF_M_FPWM;
    if (ps != 2'h0 && c[3])
      return BMF_M_LPWR;
    return BMF_M_ADAPT;
  endfunction : exp_mode
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [7:0] ra [5] = '{BMF_OFS_CTRL, BMF_OFS_SETPT, BMF_OFS_IRQ, BMF_OFS_MASK, 8'h14};
    foreach (ra[i])
    begin
      i_bmf_host.rd(ra[i], d);
      chk_w(d, 32'h0, "reset value");
    end
    chk_w(32'({buck_mode, discharge_on, irq}), 32'h2, "reset pins");
  endtask : t_reset
  // start-up load at both ends of the code range, then refused write
  task automatic t_startup();
    logic [31:0] d;
    logic [3:0] c [3] = '{4'h0, 4'hf, 4'h5};
    foreach (c[i])
    begin
      power_state <= 2'h3;
      programmed_setpoint_code <= {2'h0, c[i]};
      repeat (4) @(posedge core_clk);
      power_state <= 2'h0;
      repeat (4) @(posedge core_clk);
      i_bmf_host.rd(BMF_OFS_SETPT, d);
      chk_w(d, {14'h0, {3{2'h0, c[i]}}}, "setpoints");
      chk_w(32'(target_mv), 32'(BMF_MV_BASE + BMF_MV_STEP * c[i]), "target mv");
      chk_w(32'(active_setpoint), 32'(c[i]), "active setpoint");
    end
    i_bmf_host.wr(BMF_OFS_SETPT, 32'hffffffff);
    i_bmf_host.rd(BMF_OFS_SETPT, d);
    chk_w(d, 32'h00005145, "setpoint write");
  endtask : t_startup
  // every control word in run, standby and sleep
  task automatic t_modes();
    for (int p = 0; p < 3; p++)
      for (int c = 0; c < 32; c++)
      begin
        @(posedge core_clk);
        power_state <= p[1:0];
        if (c == 0)
          repeat (3) @(posedge core_clk);
        i_bmf_host.wr(BMF_OFS_CTRL, 32'(c));
        @(negedge core_clk);
        chk_w(32'(buck_mode), 32'(exp_mode(p[1:0], c[4:0])), "mode");
        chk_w(32'(discharge_on), 32'(exp_mode(p[1:0], c[4:0]) == BMF_M_OFF), "discharge");
      end
  endtask : t_modes
  // sense, short pulse, debounce, mask and clear
  task automatic t_fault();
    logic [31:0] d;
    int n;
    power_state <= 2'h0;
    i_bmf_host.wr(BMF_OFS_CTRL, 32'h1);
    load_light <= 1'b1;
    hs_limit_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk_w(32'(hs_gate_off), 32'h1, "hs cut");
    i_bmf_host.rd(BMF_OFS_STAT, d);
    chk_w(d, 32'h89, "sense");
    hs_limit_in <= 1'b0;
    repeat (HOLD + 5) @(posedge core_clk);
    i_bmf_host.rd(BMF_OFS_IRQ, d);
    chk_w(d, 32'h0, "short pulse");
    i_bmf_host.wr(BMF_OFS_MASK, 32'h1);
    hs_limit_in <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < HOLD + 20)
    begin
      @(negedge core_clk);
      n++;
    end
    chk_w(32'((n > HOLD) && (n < HOLD + 8)), 32'h1, "debounce span");
    @(posedge core_clk);
    hs_limit_in <= 1'b0;
    ls_limit_in <= 1'b1;
    i_bmf_host.wr(BMF_OFS_IRQ, 32'h1);
    repeat (HOLD + 10) @(posedge core_clk);
    chk_w(32'({ls_gate_off, irq}), 32'h2, "masked ls");
    ls_limit_in <= 1'b0;
    i_bmf_host.rd(BMF_OFS_IRQ, d);
    chk_w(d, 32'h2, "ls status");
    i_bmf_host.wr(BMF_OFS_MASK, 32'h3);
    @(negedge core_clk);
    chk_w(32'(irq), 32'h1, "unmasked");
    i_bmf_host.wr(BMF_OFS_IRQ, 32'h2);
    @(negedge core_clk);
    chk_w(32'(irq), 32'h0, "cleared");
  endtask : t_fault
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    $display("test reset done");
    t_startup();
    $display("test startup done");
    t_modes();
    $display("test modes done");
    t_fault();
    $display("test fault done");
    wrap_up();
  end
  initial
  begin
    #(40 * 5000);
    failures++;
    wrap_up();
  end
endmodule : tb_top
